// ==== hw/mgp_pkg.sv ====
// Shared types and constants of the multifunction general-purpose port
package mgp_pkg;

	localparam int unsigned NUM_LINES = 8;

	// Default line positions of the attach functions
	localparam logic [2:0] RX_SWITCH_LINE   = 3'h0;
	localparam logic [2:0] TX_SWITCH_LINE   = 3'h1;
	localparam logic [2:0] PULLUP_LINE_DEF  = 3'h2;
	localparam logic [2:0] WAKE_LINE_DEF    = 3'h3;
	localparam logic [2:0] PWR_LINE_DEF     = 3'h4;
	localparam logic [2:0] DETACH_LINE_DEF  = 3'h5;

	// Reset values: all lines input, outputs low
	localparam logic [7:0] DIR_RESET = 8'h00;
	localparam logic [7:0] OUT_RESET = 8'h00;

	// Product variant
	typedef enum logic {
		MGP_VAR_UART,
		MGP_VAR_BUS
	} mgp_variant_e;

	// One write request from a master (firmware or host command)
	typedef struct packed {
		logic       valid;
		logic [7:0] mask;
		logic [7:0] dir;
		logic [7:0] value;
	} mgp_req_s;

	// Attach-function mapping and enables
	typedef struct packed {
		logic       pullup_en;
		logic [2:0] pullup_line;
		logic       wake_en;
		logic [2:0] wake_line;
		logic       pwr_en;
		logic [2:0] pwr_line;
		logic       detach_en;
		logic [2:0] detach_line;
	} mgp_map_s;

	// Per-line pad signals
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe_n;
	} mgp_pad_s;

endpackage

// ==== hw/mgp_sync.sv ====
// Two-stage synchroniser for the eight pin inputs
`timescale 1ns/100ps
`default_nettype none
module mgp_sync (
	// Clock and reset
	input  wire logic       mclk_i,
	input  wire logic       resetn_i,
	// Pins and synchronised levels
	input  wire logic [7:0] pin_i,
	output var  logic [7:0] level_o
);
	import mgp_pkg::*;

	logic [7:0] meta;
	logic [7:0] next_meta;
	logic [7:0] next_level;

	// First stage feeds only the second
	always_comb begin
		next_meta  = pin_i;
		next_level = meta;
	end

	// Undriven lines read low, so reset to low
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			meta    <= 8'h00;
			level_o <= 8'h00;
		end else begin
			meta    <= next_meta;
			level_o <= next_level;
		end
	end
endmodule
`default_nettype wire

// ==== hw/mgp_port.sv ====
// Eight-line general-purpose port with attach-function muxing
// Summary of operation
// R1 - The port has eight lines 7..0, each individually set as input or output.
// R2 - Both the embedded firmware and host vendor commands can read and drive the lines.
// R3 - Line 0 carries the receive-switch control and line 1 the transmit-switch control, kept for compatibility only.
// R4 - Line 2 is a plain line on the serial variant and may drive the data pull-up on the bus variant.
// R5 - Line 3 is plain on the serial variant and, on the bus variant, a setting picks plain use or host wake-up.
// R6 - Lines 4 and 5 are plain on the serial variant and may be power-present and detach inputs on the bus variant.
// R7 - The bus attach functions can be mapped by software to any of the eight lines.
// R8 - While reset is asserted every bidirectional pin is an input and every output is high impedance.
// R9 - Each line has a weak pull-down so an undriven line reads low.
// R10 - The outside reset source should hold reset for longer than 5 ms.
// R11 - The outside party must reset the module at every start-up with a proper reset source.
// R12 - Each line holds a direction bit and an output bit and reads back the sampled pin level.
`timescale 1ns/100ps
`default_nettype none
module mgp_port (
	// Clock and reset
	input  wire logic                 mclk_i,
	input  wire logic                 resetn_i,
	// Variant strap and attach mapping
	input  wire mgp_pkg::mgp_variant_e variant_i,
	input  wire mgp_pkg::mgp_map_s    map_i,
	// Firmware and host command ports
	input  wire mgp_pkg::mgp_req_s    fw_req_i,
	input  wire mgp_pkg::mgp_req_s    host_req_i,
	// Radio switch controls and attach functions
	input  wire logic                 rx_switch_ctrl_i,
	input  wire logic                 tx_switch_ctrl_i,
	input  wire logic                 radio_switch_en_i,
	input  wire logic                 pullup_drive_i,
	input  wire logic                 wake_drive_i,
	output logic                      bus_power_o,
	output logic                      bus_detach_request_o,
	// Read-back
	output logic [7:0]                gp_lines_o,
	output logic [7:0]                dir_o,
	output logic [7:0]                out_val_o,
	// Pads
	input  wire logic [7:0]           pad_i,
	output logic [7:0]                pad_o,
	output logic [7:0]                pad_oe_n_o,
	output logic [7:0]                pad_pulldown_o
);
	import mgp_pkg::*;

	logic [7:0]     level;
	logic [7:0]     dir;
	logic [7:0]     out_val;
	logic [7:0]     next_dir;
	logic [7:0]     next_out_val;
	mgp_pad_s       pad;
	mgp_pad_s       next_pad;
	logic           bus_ok;
	logic           next_bus_power;
	logic           next_detach;

	// Pin levels cross into the clock domain first
	mgp_sync u_sync (
		.mclk_i   (mclk_i),
		.resetn_i (resetn_i),
		.pin_i    (pad_i),
		.level_o  (level)
	);

	// Direction and output bits; host command wins a same-cycle clash
	always_comb begin
		next_dir     = dir;
		next_out_val = out_val;
		if (fw_req_i.valid) begin // [R2]
			next_dir     = (next_dir & ~fw_req_i.mask) | (fw_req_i.dir & fw_req_i.mask); // [R1] [R12]
			next_out_val = (next_out_val & ~fw_req_i.mask) | (fw_req_i.value & fw_req_i.mask);
		end
		if (host_req_i.valid) begin // [R2]
			next_dir     = (next_dir & ~host_req_i.mask) | (host_req_i.dir & host_req_i.mask);
			next_out_val = (next_out_val & ~host_req_i.mask) | (host_req_i.value & host_req_i.mask);
		end
	end

	// All lines input with reset held
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			dir     <= DIR_RESET; // [R8]
			out_val <= OUT_RESET;
		end else begin
			dir     <= next_dir;
			out_val <= next_out_val;
		end
	end

	assign bus_ok = (variant_i == MGP_VAR_BUS); // [R4] [R5] [R6]

	// Per-line pad mux: attach functions override plain use
	for (genvar i = 0; i < NUM_LINES; i++) begin : g_line
		always_comb begin
			next_pad.out[i]  = out_val[i];
			next_pad.oe_n[i] = ~dir[i]; // [R1]
			if (radio_switch_en_i && (i == int'(RX_SWITCH_LINE))) begin
				next_pad.out[i]  = rx_switch_ctrl_i; // [R3]
				next_pad.oe_n[i] = 1'b0;
			end
			if (radio_switch_en_i && (i == int'(TX_SWITCH_LINE))) begin
				next_pad.out[i]  = tx_switch_ctrl_i; // [R3]
				next_pad.oe_n[i] = 1'b0;
			end
			// Mapped lines may move anywhere; mapped functions act only with the bus strap
			if (bus_ok && map_i.pullup_en && (map_i.pullup_line == 3'(i))) begin
				next_pad.out[i]  = pullup_drive_i; // [R4] [R7]
				next_pad.oe_n[i] = 1'b0;
			end
			if (bus_ok && map_i.wake_en && (map_i.wake_line == 3'(i))) begin
				next_pad.out[i]  = wake_drive_i; // [R5] [R7]
				next_pad.oe_n[i] = 1'b0;
			end
			// Input functions force the line to input
			if (bus_ok && ((map_i.pwr_en && (map_i.pwr_line == 3'(i))) ||
				(map_i.detach_en && (map_i.detach_line == 3'(i))))) begin
				next_pad.oe_n[i] = 1'b1; // [R6] [R7]
			end
		end
	end

	// Attach inputs taken from the synchronised level
	always_comb begin
		next_bus_power = bus_ok & map_i.pwr_en & level[map_i.pwr_line]; // [R6] [R7]
		next_detach    = bus_ok & map_i.detach_en & level[map_i.detach_line];
	end

	// Output registers; pads released during reset
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			pad.out              <= 8'h00;
			pad.oe_n             <= 8'hff; // [R8]
			bus_power_o          <= 1'b0;
			bus_detach_request_o <= 1'b0;
		end else begin
			pad                  <= next_pad;
			bus_power_o          <= next_bus_power;
			bus_detach_request_o <= next_detach;
		end
	end

	// Read-back of levels and settings
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			gp_lines_o     <= 8'h00;
			dir_o          <= DIR_RESET;
			out_val_o      <= OUT_RESET;
			pad_pulldown_o <= 8'hff;
		end else begin
			gp_lines_o     <= level; // [R12]
			dir_o          <= dir;
			out_val_o      <= out_val;
			pad_pulldown_o <= 8'hff; // [R9] weak pull-down always on
		end
	end

	assign pad_o      = pad.out;
	assign pad_oe_n_o = pad.oe_n;

	// Checks
	// A direction write takes two edges to reach the pad: one into dir, one into the pad flop
	sequence s_host_sets_line7;
		host_req_i.valid && host_req_i.mask[7] && host_req_i.dir[7] && !map_i.pwr_en && !map_i.detach_en &&
		!map_i.pullup_en && !map_i.wake_en;
	endsequence
	sequence s_line7_driven;
		##1 !pad_oe_n_o[7];
	endsequence

	a_reset_input: assert property (@(posedge mclk_i) !resetn_i |=> pad_oe_n_o == 8'hff) // [R8]
		else $error("pads driven after reset");
	a_reset_regs: assert property (@(posedge mclk_i) !resetn_i |=> (dir_o == 8'h00 && out_val_o == 8'h00 && // [R8]
		!bus_power_o && !bus_detach_request_o))
		else $error("settings not cleared by reset");
	a_dir_drive: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		s_host_sets_line7 |=> s_line7_driven) // [R1]
		else $error("line 7 not driven after dir set");
	a_readback_lvl: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		##3 gp_lines_o == $past(pad_i, 3)) // [R12]
		else $error("read-back level wrong");
	// Mask is taken from the request cycle; the live mask may have moved on
	a_host_wins: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(fw_req_i.valid && host_req_i.valid) |=> // [R2]
		((dir & $past(host_req_i.mask)) == ($past(host_req_i.dir) & $past(host_req_i.mask))))
		else $error("host write lost");
	a_uart_no_pwr: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(variant_i == MGP_VAR_UART) |=> !bus_power_o) // [R6]
		else $error("bus power on serial variant");
	a_rx_switch: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(radio_switch_en_i && !bus_ok) |=> (!pad_oe_n_o[0] && pad_o[0] == $past(rx_switch_ctrl_i))) // [R3]
		else $error("receive switch not on line 0");
	a_tx_switch: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(radio_switch_en_i && !bus_ok) |=> (!pad_oe_n_o[1] && pad_o[1] == $past(tx_switch_ctrl_i))) // [R3]
		else $error("transmit switch not on line 1");
	// Only the line itself must be free of higher-priority functions
	a_pullup_map: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(bus_ok && map_i.pullup_en && map_i.pullup_line == 3'h6 && !(map_i.wake_en && map_i.wake_line == 3'h6) &&
		!(map_i.pwr_en && map_i.pwr_line == 3'h6) && !(map_i.detach_en && map_i.detach_line == 3'h6))
		|=> (!pad_oe_n_o[6] && pad_o[6] == $past(pullup_drive_i))) // [R4] [R7]
		else $error("pull-up not on mapped line");
	a_wake_map: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(bus_ok && map_i.wake_en && map_i.wake_line == 3'h2 && !(map_i.pwr_en && map_i.pwr_line == 3'h2) &&
		!(map_i.detach_en && map_i.detach_line == 3'h2))
		|=> (!pad_oe_n_o[2] && pad_o[2] == $past(wake_drive_i))) // [R5] [R7]
		else $error("wake line not driven");
	// A mapped input function must never fight the outside driver
	a_detach_input: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(bus_ok && map_i.detach_en) |=> pad_oe_n_o[$past(map_i.detach_line)]) // [R6] [R7]
		else $error("detach line not released");
	a_pulldown_on: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		##1 pad_pulldown_o == 8'hff) // [R9]
		else $error("pull-down missing");
endmodule
`default_nettype wire

// ==== tb/mgp_ext.sv ====
// Model of the outside circuitry on the eight port pins
`timescale 1ns/100ps
`default_nettype none
module mgp_ext (
	// Pad side of the port
	input  wire logic [7:0] pad_o,
	input  wire logic [7:0] pad_oe_n_o,
	input  wire logic [7:0] pad_pulldown_o,
	// Outside drivers
	input  wire logic [7:0] ext_en_i,
	input  wire logic [7:0] ext_val_i,
	output logic      [7:0] pad_i
);
	// Device drive first, then outside drive, then the weak pull-down
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (!pad_oe_n_o[i])
				pad_i[i] = pad_o[i];
			else if (ext_en_i[i])
				pad_i[i] = ext_val_i[i];
			else
				pad_i[i] = !pad_pulldown_o[i]; // Missing pull-down floats high
		end
	end
endmodule
`default_nettype wire

// ==== tb/multifunction_gpio_port_bench.sv ====
// Self-checking bench for the multifunction general-purpose port
`timescale 1ns/100ps
`default_nettype none
module multifunction_gpio_port_bench;
	import mgp_pkg::*;
	logic         mclk_i = 0;
	logic         resetn_i = 0;
	mgp_variant_e var_s = MGP_VAR_UART;
	mgp_map_s     map = '0;
	mgp_req_s     fw = '0;
	mgp_req_s     host = '0;
	logic [4:0]   ctl = '0; // rx, tx, radio enable, pull-up drive, wake drive
	logic [7:0]   ext_en = '0;
	logic [7:0]   ext_val = '0;
	logic         pwr;
	logic         det;
	logic [7:0]   gp, dir, outv, pad, oe_n, pd, pin;
	int           n_mismatch = 0;
	int           n_tests = 0;
	int           cyc = 0;
	// Rows: fw mask/dir/value, host mask/dir/value, expected dir and out
	logic [7:0]   rows [5][8] = '{'{8'hff, 8'h0f, 8'h05, 8'h00, 8'h00, 8'h00, 8'h0f, 8'h05},
		'{8'h00, 8'h00, 8'h00, 8'hf0, 8'hf0, 8'ha0, 8'hff, 8'ha5},
		'{8'h3c, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'hc3, 8'hbd},
		'{8'hff, 8'hff, 8'hff, 8'h0f, 8'hff, 8'h00, 8'hff, 8'hf0},
		'{8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00}};

	mgp_port dut (.mclk_i(mclk_i), .resetn_i(resetn_i), .variant_i(var_s), .map_i(map), .fw_req_i(fw),
		.host_req_i(host), .rx_switch_ctrl_i(ctl[4]), .tx_switch_ctrl_i(ctl[3]), .radio_switch_en_i(ctl[2]),
		.pullup_drive_i(ctl[1]), .wake_drive_i(ctl[0]), .bus_power_o(pwr), .bus_detach_request_o(det),
		.gp_lines_o(gp), .dir_o(dir), .out_val_o(outv), .pad_i(pin), .pad_o(pad), .pad_oe_n_o(oe_n),
		.pad_pulldown_o(pd));
	mgp_ext ext (.pad_o(pad), .pad_oe_n_o(oe_n), .pad_pulldown_o(pd), .ext_en_i(ext_en), .ext_val_i(ext_val),
		.pad_i(pin));

	// Free-running clock
	initial begin
		forever #10 mclk_i = ~mclk_i;
	end

	task automatic final_report();
		if (n_mismatch == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask

	// One write cycle on both masters; a zero mask leaves that master idle
	task automatic wr(input logic [7:0] r [8]);
		@(posedge mclk_i);
		fw <= '{(r[0] != 8'h00), r[0], r[1], r[2]};
		host <= '{(r[3] != 8'h00), r[3], r[4], r[5]};
		@(posedge mclk_i);
		fw.valid <= 1'b0;
		host.valid <= 1'b0;
		repeat (6) @(posedge mclk_i);
		#1;
	endtask

	task automatic chk_rst();
		chk(oe_n, 8'hff);
		chk(pad, 8'h00);
		chk(dir, 8'h00);
		chk(outv, 8'h00);
		chk(gp, 8'h00);
		chk(pd, 8'hff);
	endtask

	// Hang guard, ample for the sequence below
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 3000) begin
			n_mismatch++;
			final_report();
		end
	end

	initial begin
		repeat (11) @(posedge mclk_i);
		#1 chk_rst();
		@(posedge mclk_i);
		resetn_i <= 1'b1; // clean reset held from start-up
		ext_en <= 8'hff;
		ext_val <= 8'ha5;
		foreach (rows[r]) begin
			wr(rows[r]);
			chk(dir, rows[r][6]);
			chk(outv, rows[r][7]);
			chk(oe_n, ~rows[r][6]);
			chk(pad & rows[r][6], rows[r][7] & rows[r][6]);
			chk(gp, (rows[r][6] & rows[r][7]) | (~rows[r][6] & 8'ha5));
		end
		// Undriven inputs read low
		@(posedge mclk_i);
		ext_en <= 8'h00;
		ctl <= 5'b10100;
		repeat (6) @(posedge mclk_i);
		#1 chk(gp & 8'hfc, 8'h00);
		chk({oe_n[1:0], pad[1:0]}, 8'h01);
		// Bus variant with functions mapped off their default lines
		@(posedge mclk_i);
		ctl <= 5'b00011;
		var_s <= MGP_VAR_BUS;
		map <= '{1'b1, 3'h6, 1'b1, 3'h2, 1'b1, 3'h7, 1'b1, 3'h3};
		ext_en <= 8'h88;
		ext_val <= 8'h88;
		repeat (8) @(posedge mclk_i);
		#1 chk({pad[6], pad[2], oe_n[6], oe_n[2], oe_n[7], oe_n[3], pwr, det}, 8'hcf);
		@(posedge mclk_i);
		var_s <= MGP_VAR_UART;
		repeat (8) @(posedge mclk_i);
		#1 chk({pwr, det, oe_n[6], oe_n[2]}, 8'h03);
		// Reset in mid-run with every line driving
		@(posedge mclk_i);
		ext_en <= 8'h00;
		wr('{8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
		@(posedge mclk_i);
		resetn_i <= 1'b0;
		repeat (2) @(posedge mclk_i);
		#1 chk_rst();
		final_report();
	end
endmodule
`default_nettype wire
